// ==== rtl/sdram_wr_pkg.sv ====
// shared constants and carrier types for the write-burst capture block
// assumes one 10 MHz clock domain; pins arrive unsynchronised
`default_nettype none
package sdram_wr_pkg;
  localparam int DQ_WIDTH = 8;
  localparam int BANK_BITS = 4;
  localparam int BANKS = 16;
  localparam int REC_WIDTH = 5;
  localparam int LAT_WIDTH = 6;
  localparam logic [1:0] BL_FIELD_BL8 = 2'h0;
  localparam logic [1:0] BL_FIELD_OTF = 2'h1;
  localparam logic [1:0] BL_FIELD_BC4 = 2'h2;
  // two beats per clock: rising and falling edge data arrive as one pair
  localparam logic [2:0] CLOCKS_BL8 = 3'h4;
  localparam logic [2:0] CLOCKS_BC4 = 3'h2;
  localparam logic [2:0] CLOCKS_CRC = 3'h1;
  localparam logic [2:0] CLOCKS_LAST = 3'h1;
  localparam logic [LAT_WIDTH-1:0] LAT_MIN = 6'h01;
  localparam logic [3:0] ADDR_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_TIMING = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_COUNT = 4'hC;
  localparam int STATUS_OVERFLOW_BIT = 2;

  typedef struct packed {
    logic parityEnable;
    logic crcEnable;
    logic dbiEnable;
    logic [1:0] burstLength;
  } config_t;

  typedef struct packed {
    logic [2:0] pad3;
    logic [REC_WIDTH-1:0] inversionWriteRecoveryTime;
    logic [2:0] pad2;
    logic [REC_WIDTH-1:0] writeRecoveryTime;
    logic [4:0] pad1;
    logic [2:0] parityLatency;
    logic [2:0] pad0;
    logic [4:0] writeLatency;
  } timing_t;

  localparam config_t CONFIG_RESET = 5'h00;
  localparam timing_t TIMING_RESET = 32'h0D0C_0009;

  typedef struct packed {
    logic write;
    logic autoPrecharge;
    logic chopSelectAddressBit;
    logic [BANK_BITS-1:0] bank;
  } cmdPins_t;

  typedef struct packed {
    logic valid;
    logic chop;
    logic autoPrecharge;
    logic [BANK_BITS-1:0] bank;
  } lineEntry_t;

  typedef struct packed {
    logic last;
    logic chop;
    logic [2*DQ_WIDTH-1:0] data;
  } beatPair_t;
endpackage
`default_nettype wire

// ==== rtl/data_fifo.sv ====
// first-in first-out buffer with valid/ready on both sides
// assumes both sides on clk; full and empty are registered flags
`default_nettype none
module data_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] DEPTH_COUNT = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST_INDEX = PW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [PW:0] count;
    logic notFull;
    logic notEmpty;
  } fifoState_t;

  fifoState_t s, n;
  logic push, pop;

  always_comb
  begin
    n = s;
    push = inValid && s.notFull;
    pop = outReady && s.notEmpty;
    if (push)
    begin
      n.mem[s.wrPtr] = inData;
      n.wrPtr = (s.wrPtr == LAST_INDEX) ? '0 : s.wrPtr + 1'b1;
    end
    if (pop)
      n.rdPtr = (s.rdPtr == LAST_INDEX) ? '0 : s.rdPtr + 1'b1;
    if (push && !pop)
      n.count = s.count + 1'b1;
    else if (pop && !push)
      n.count = s.count - 1'b1;
    n.notFull = n.count != DEPTH_COUNT;
    n.notEmpty = n.count != '0;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s <= '0;
      s.notFull <= 1'b1;
    end
    else
      s <= n;
  end

  assign inReady = s.notFull;
  assign outValid = s.notEmpty;
  assign outData = s.mem[s.rdPtr];
endmodule
`default_nettype wire

// ==== rtl/bank_recovery.sv ====
// write-recovery countdown for one bank, fires the internal precharge
// assumes start is a one-cycle pulse in the cycle of the final data pair, or of the crc pair when crc is on
`default_nettype none
module bank_recovery #(
  parameter int COUNT_WIDTH = 5
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [COUNT_WIDTH-1:0] cycles,
  output logic busy,
  output logic fire
);
  localparam logic [COUNT_WIDTH-1:0] ONE = COUNT_WIDTH'(1);

  typedef struct packed {
    logic [COUNT_WIDTH-1:0] count;
    logic busy;
    logic fire;
  } recState_t;

  recState_t s, n;

  always_comb
  begin
    n = s;
    n.fire = 1'b0;
    if (start)
    begin
      // zero would wrap and run the whole count before firing; treat it as one cycle
      n.count = (cycles == '0) ? ONE : cycles;
      n.busy = 1'b1;
    end
    else if (s.busy)
    begin
      n.count = s.count - ONE;
      if (s.count == ONE)
      begin
        n.busy = 1'b0;
        n.fire = 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      s <= '0;
    else
      s <= n;
  end

  assign busy = s.busy;
  assign fire = s.fire;
endmodule
`default_nettype wire

// ==== rtl/sdram_write_burst.sv ====
// write-burst capture of the memory device: burst length, data capture, recovery
// assumes command and data pins from the controller, classic Wishbone slave
// Function
// - With the burst-length field at 1:0 every write is a four-beat chop, ignoring the chop bit.
// - With the field at 0:1 a write whose chop bit is low is a four-beat chop.
// - Field 0:0, or field 0:1 with the chop bit high, gives an eight-beat burst.
// - In per-command mode each write picks its own length, mixed freely back to back.
// - Auto-precharge starts after the write recovery count from the edge after the last beat.
// - With CRC on writes may come five clocks apart and recovery follows the CRC beat.
//
// Implementation choices: register access over Wishbone and the address map.
`default_nettype none
module sdram_write_burst
  import sdram_wr_pkg::*;
#(
  parameter int FIFO_DEPTH = 8,
  parameter int LINE_DEPTH = 32
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire sdram_wr_pkg::cmdPins_t cmdPins,
  input wire logic [2*sdram_wr_pkg::DQ_WIDTH-1:0] dqPair,
  output sdram_wr_pkg::beatPair_t memWrData,
  output logic memWrValid,
  input wire logic memWrReady,
  output logic captureReady,
  output logic burstActive,
  output logic [sdram_wr_pkg::BANKS-1:0] prechargeStart
);
  import sdram_wr_pkg::*;

  // gray order along idle, data, crc
  typedef enum logic [1:0]
  {
    PHASE_IDLE = 2'h0,
    PHASE_DATA = 2'h1,
    PHASE_CRC = 2'h3
  } phase_t;

  typedef struct packed {
    cmdPins_t cmdMeta;
    cmdPins_t cmdSync;
    logic [2*DQ_WIDTH-1:0] dqMeta;
    logic [2*DQ_WIDTH-1:0] dqSync;
    logic [2*DQ_WIDTH-1:0] dqHold;
    config_t cfg;
    timing_t tim;
    lineEntry_t [LINE_DEPTH-1:0] line;
    phase_t phase;
    logic inBurst;
    logic [2:0] clocksLeft;
    logic crcBurst;
    lineEntry_t cur;
    logic lastChop;
    logic overflow;
    logic [31:0] burstCount;
    logic ack;
    logic [31:0] rdData;
    beatPair_t outData;
    logic outValid;
  } state_t;

  localparam logic [LAT_WIDTH-1:0] LAT_MAX = LAT_WIDTH'(LINE_DEPTH);
  localparam int BYTE_LANES = 4;
  localparam int LANE_BITS = 8;

  state_t s, n;
  logic chopNow;
  logic [LAT_WIDTH-1:0] latency;
  lineEntry_t entry;
  logic dataCycle;
  logic lastData;
  logic [2:0] clocksNew;
  logic fifoInValid;
  logic fifoInReady;
  beatPair_t fifoInData;
  beatPair_t fifoOutData;
  logic fifoOutValid;
  logic fifoOutReady;
  logic [REC_WIDTH-1:0] recCycles;
  logic [BANKS-1:0] recStart;
  logic [BANKS-1:0] recBusy;
  logic [31:0] timingWord;
  logic [31:0] wrWord;
  logic [31:0] oldWord;
  logic busWrite;

  always_comb
  begin
    n = s;
    // two-stage synchronisers; only the second stage is read below
    n.cmdMeta = cmdPins;
    n.cmdSync = s.cmdMeta;
    n.dqMeta = dqPair;
    n.dqSync = s.dqMeta;
    // one more stage lines the first data pair up with the burst flag
    n.dqHold = s.dqSync;

    // burst length decode
    case (s.cfg.burstLength)
      BL_FIELD_BC4: chopNow = 1'b1;
      BL_FIELD_OTF: chopNow = !s.cmdSync.chopSelectAddressBit;
      BL_FIELD_BL8: chopNow = 1'b0;
      default: chopNow = 1'b0;
    endcase

    latency = LAT_WIDTH'(s.tim.writeLatency);
    if (s.cfg.parityEnable)
      latency = latency + LAT_WIDTH'(s.tim.parityLatency);
    if (latency < LAT_MIN)
      latency = LAT_MIN;
    if (latency > LAT_MAX)
      latency = LAT_MAX;

    // delay line: an entry reaches index 0 in the cycle its first data pair arrives
    for (int i = 0; i < LINE_DEPTH - 1; i++)
      n.line[i] = s.line[i+1];
    n.line[LINE_DEPTH-1] = '0;
    entry.valid = 1'b1;
    entry.chop = chopNow;
    entry.autoPrecharge = s.cmdSync.autoPrecharge;
    entry.bank = s.cmdSync.bank;
    // anything but a write is deselect or another command and is ignored here
    if (s.cmdSync.write)
      n.line[latency - LAT_MIN] = entry;

    // crc pair trails the data pairs; it is counted but not stored
    dataCycle = s.phase == PHASE_DATA;
    lastData = s.inBurst && s.clocksLeft == CLOCKS_LAST;
    fifoInValid = dataCycle;
    fifoInData.data = s.dqHold;
    fifoInData.chop = s.cur.chop;
    fifoInData.last = s.clocksLeft == (s.crcBurst ? CLOCKS_LAST + CLOCKS_CRC : CLOCKS_LAST);
    // the pins cannot be stalled: a full buffer drops the pair and flags it
    if (dataCycle && !fifoInReady)
      n.overflow = 1'b1;

    // inversion recovery applies only while crc is off
    recCycles = (s.cfg.dbiEnable && !s.cfg.crcEnable)
      ? s.tim.inversionWriteRecoveryTime : s.tim.writeRecoveryTime;
    recStart = '0;
    if (lastData && s.cur.autoPrecharge)
      recStart[s.cur.bank] = 1'b1;

    if (s.inBurst)
      n.clocksLeft = s.clocksLeft - CLOCKS_LAST;
    if (lastData)
      n.burstCount = s.burstCount + 32'h0000_0001;
    // data clocks first, then one crc clock when crc is on
    case (s.phase)
      PHASE_IDLE: n.phase = PHASE_IDLE;
      PHASE_DATA:
      begin
        if (s.clocksLeft == CLOCKS_LAST)
          n.phase = PHASE_IDLE;
        else if (s.crcBurst && s.clocksLeft == CLOCKS_LAST + CLOCKS_CRC)
          n.phase = PHASE_CRC;
      end
      PHASE_CRC: n.phase = PHASE_IDLE;
      default: n.phase = PHASE_IDLE;
    endcase
    // a new burst at its tap takes over; legal spacing ends the old one first
    if (s.line[0].valid)
    begin
      clocksNew = s.line[0].chop ? CLOCKS_BC4 : CLOCKS_BL8;
      if (s.cfg.crcEnable)
        clocksNew = clocksNew + CLOCKS_CRC;
      n.phase = PHASE_DATA;
      n.clocksLeft = clocksNew;
      n.crcBurst = s.cfg.crcEnable;
      n.cur = s.line[0];
      n.lastChop = s.line[0].chop;
    end
    else
      clocksNew = '0;
    // registered copy keeps burstActive straight from a flop
    n.inBurst = n.phase != PHASE_IDLE;

    // output stage keeps memWrData straight from a flop
    fifoOutReady = !s.outValid || memWrReady;
    if (fifoOutReady)
    begin
      n.outValid = fifoOutValid;
      n.outData = fifoOutData;
    end

    // wishbone classic: ack one cycle, write lands at the edge that samples ack
    n.ack = cyc_i && stb_i && !s.ack;
    timingWord = s.tim;
    oldWord = '0;
    case (adr_i)
      ADDR_CONFIG: oldWord = 32'(s.cfg);
      ADDR_TIMING: oldWord = timingWord;
      ADDR_STATUS: oldWord = {recBusy, 13'h0000, s.overflow, s.lastChop, s.inBurst};
      ADDR_COUNT: oldWord = s.burstCount;
      default: oldWord = '0;
    endcase
    if (n.ack)
      n.rdData = oldWord;
    wrWord = oldWord;
    for (int b = 0; b < BYTE_LANES; b++)
      if (sel_i[b])
        wrWord[LANE_BITS*b +: LANE_BITS] = dat_i[LANE_BITS*b +: LANE_BITS];
    // the write lands at the edge that samples ack, not at the request edge
    busWrite = cyc_i && stb_i && s.ack && we_i;
    if (busWrite)
    begin
      case (adr_i)
        ADDR_CONFIG: n.cfg = config_t'(wrWord[$bits(config_t)-1:0]);
        ADDR_TIMING:
        begin
          n.tim = timing_t'(wrWord);
          n.tim.pad0 = '0;
          n.tim.pad1 = '0;
          n.tim.pad2 = '0;
          n.tim.pad3 = '0;
        end
        // write one to clear, but a fresh overflow in this cycle wins
        ADDR_STATUS:
          if (sel_i[0] && dat_i[STATUS_OVERFLOW_BIT] && !(dataCycle && !fifoInReady))
            n.overflow = 1'b0;
        default: n.cfg = s.cfg;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s <= '0;
      s.cfg <= CONFIG_RESET;
      s.tim <= TIMING_RESET;
    end
    else
      s <= n;
  end

  data_fifo #(
    .WIDTH($bits(beatPair_t)),
    .DEPTH(FIFO_DEPTH)
  ) pairFifo (
    .clk(clk),
    .reset(reset),
    .inData(fifoInData),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .outData(fifoOutData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady)
  );

  // one countdown per bank so overlapping auto-precharges do not collide
  for (genvar g = 0; g < BANKS; g++)
  begin : recovery
    bank_recovery #(
      .COUNT_WIDTH(REC_WIDTH)
    ) counter (
      .clk(clk),
      .reset(reset),
      .start(recStart[g]),
      .cycles(recCycles),
      .busy(recBusy[g]),
      .fire(prechargeStart[g])
    );
  end

  assign dat_o = s.rdData;
  assign ack_o = s.ack;
  assign memWrData = s.outData;
  assign memWrValid = s.outValid;
  assign captureReady = fifoInReady;
  assign burstActive = s.inBurst;
endmodule
`default_nettype wire

// ==== tb/sdram_wr_checker.sv ====
// port checker for the write-burst block
// assumes one clock with a synchronous active-high reset
`default_nettype none
module sdram_wr_checker
  import sdram_wr_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic [31:0] dat_o,
  input wire sdram_wr_pkg::beatPair_t memWrData,
  input wire logic memWrValid,
  input wire logic memWrReady,
  input wire logic captureReady,
  input wire logic burstActive,
  input wire logic [sdram_wr_pkg::BANKS-1:0] prechargeStart
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  ack_once_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered");
  ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  rdata_hold_a: assert property (!ack_o |-> $stable(dat_o))
    else $error("read data moved");
  reset_state_a: assert property (disable iff (1'b0) reset |=> !ack_o && !memWrValid
    && captureReady && !burstActive && prechargeStart == '0)
    else $error("bad state after reset");
  pair_hold_a: assert property (memWrValid && !memWrReady |=> memWrValid && $stable(memWrData))
    else $error("stalled pair changed");
  full_data_a: assert property (!captureReady |-> memWrValid)
    else $error("full with nothing offered");
  burst_span_a: assert property ($rose(burstActive) |-> burstActive[*2] ##[1:7] !burstActive)
    else $error("burst span wrong");
  precharge_pulse_a: assert property (prechargeStart != '0 |=>
    (prechargeStart & $past(prechargeStart)) == '0)
    else $error("precharge start not a pulse");
endmodule
bind sdram_write_burst sdram_wr_checker sdram_wr_checker_i (.clk, .reset, .cyc_i, .stb_i,
  .ack_o, .dat_o, .memWrData, .memWrValid, .memWrReady, .captureReady, .burstActive,
  .prechargeStart);
`default_nettype wire

// ==== tb/ctrl_model.sv ====
// controller model: write commands and data pairs on the pins
// assumes calls start just after a clock edge
`default_nettype none
module ctrl_model
  import sdram_wr_pkg::*;
(
  input wire logic clk,
  output sdram_wr_pkg::cmdPins_t cmdPins,
  output logic [2*sdram_wr_pkg::DQ_WIDTH-1:0] dqPair
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] beat = 16'h0000;
  logic beatOn = 1'b0;
  logic [15:0] idle = 16'h5A5A;
  // released lines keep changing so a stale beat never looks valid
  always @(posedge clk) idle <= ~idle;
  assign dqPair = beatOn ? beat : idle;
  initial cmdPins = '0;
  task automatic wr(input logic [3:0] bank, input logic chop, input int lat, input int n);
    @(posedge clk);
    cmdPins <= {1'b1, 1'b1, chop, bank};
    @(posedge clk);
    cmdPins <= '0;
    repeat (lat - 1) @(posedge clk);
    for (int k = 0; k < n; k++)
    begin
      if (k > 0) @(posedge clk);
      beat <= {4'hA, bank, 8'(k)};
      beatOn <= 1'b1;
    end
    @(posedge clk);
    beatOn <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== tb/sdram_write_burst_tb_top.sv ====
// bench for the write-burst block: bus tasks, burst runs, fifo stall
// assumes the controller model and the bound checker
`default_nettype none
module sdram_write_burst_tb_top;
  import sdram_wr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] adr_i = 4'h0;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, q;
  logic we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, ack_o;
  cmdPins_t cmdPins;
  logic [15:0] dqPair, lastData;
  beatPair_t memWrData;
  logic memWrValid, captureReady, burstActive, lastFlag, chopSeen;
  logic memWrReady = 1'b0, hold = 1'b0, sawFull = 1'b0;
  logic [BANKS-1:0] prechargeStart, pcMask;
  int errors = 0, checked = 0, cyc = 0, act, pairs, lastAct, pcAt;

  initial forever #50 clk = ~clk;
  sdram_write_burst sdram_write_burst_i (.clk, .reset, .adr_i, .dat_i, .dat_o, .we_i, .sel_i,
    .cyc_i, .stb_i, .ack_o, .cmdPins, .dqPair, .memWrData, .memWrValid, .memWrReady,
    .captureReady, .burstActive, .prechargeStart);
  ctrl_model ctrl_model_i (.clk, .cmdPins, .dqPair);

  always @(posedge clk)
  begin
    cyc++;
    // far side stalls every other cycle, or fully while held
    memWrReady <= hold ? 1'b0 : ~memWrReady;
    if (!captureReady) sawFull = 1'b1;
    if (burstActive) lastAct = cyc;
    if (burstActive) act++;
    if (memWrValid && memWrReady)
    begin
      pairs++;
      lastFlag = memWrData.last;
      chopSeen = memWrData.chop;
      lastData = memWrData.data;
    end
    if (prechargeStart != '0)
    begin
      pcAt = cyc;
      pcMask = prechargeStart;
    end
  end

  task finish_test;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    adr_i <= a;
    we_i <= w;
    dat_i <= d;
    sel_i <= 4'hF;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    // ack and read data are taken at one rising edge; only the watchdog ends a hang
    do @(posedge clk); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task vfy(input int nClk, input int n, input int idx, input logic ch, input int rec,
    input logic [3:0] bank);
    repeat (40) @(posedge clk);
    chk("clocks", act, nClk);
    chk("pairs", pairs, n);
    chk("last", lastFlag, 1'b1);
    chk("chop", chopSeen, ch);
    chk("data", lastData, {4'hA, bank, 8'(idx)});
    // pulse starts rec edges after the reference edge and is seen one edge later
    chk("recovery", pcAt - lastAct, rec + 1);
    chk("bank", pcMask, 16'h0001 << bank);
  endtask

  task run(input logic [4:0] cfg, input logic ch, input int n, input int crc, input int lat,
    input int rec, input logic [3:0] bank);
    wb(ADDR_CONFIG, 1'b1, {27'h0, cfg});
    act = 0;
    pairs = 0;
    ctrl_model_i.wr(bank, ch, lat, n + crc);
    vfy(n + crc, n, n - 1, n == 2, rec, bank);
  endtask

  task two(input logic [4:0] cfg, input int gap, input int crc, input logic [3:0] bank);
    wb(ADDR_CONFIG, 1'b1, {27'h0, cfg});
    act = 0;
    pairs = 0;
    fork
      ctrl_model_i.wr(bank - 4'h1, 1'b0, 3, 2 + crc);
      begin
        repeat (gap) @(posedge clk);
        ctrl_model_i.wr(bank, 1'b1, 3, 4 + crc);
      end
    join
    vfy(6 + 2 * crc, 6, 3, 1'b0, 4, bank);
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    wb(ADDR_CONFIG, 1'b0, 32'h0);
    chk("config", q, 32'h0);
    wb(ADDR_TIMING, 1'b0, 32'h0);
    chk("timing", q, TIMING_RESET);
    wb(4'h2, 1'b0, 32'h0);
    chk("unmapped", q, 32'h0);
    wb(ADDR_TIMING, 1'b1, 32'h0604_0203);
    run(5'h00, 1'b0, 4, 0, 3, 4, 4'h0);
    run(5'h02, 1'b1, 2, 0, 3, 4, 4'h1);
    run(5'h01, 1'b0, 2, 0, 3, 4, 4'h2);
    run(5'h01, 1'b1, 4, 0, 3, 4, 4'h3);
    run(5'h03, 1'b0, 4, 0, 3, 4, 4'h4);
    run(5'h04, 1'b0, 4, 0, 3, 6, 4'h5);
    run(5'h0C, 1'b0, 4, 1, 3, 4, 4'h6);
    run(5'h11, 1'b0, 2, 0, 5, 4, 4'h7);
    two(5'h01, 4, 0, 4'h9);
    two(5'h09, 5, 1, 4'hC);
    wb(ADDR_COUNT, 1'b0, 32'h0);
    chk("count", q, 32'h0000_000C);
    hold <= 1'b1;
    repeat (3) ctrl_model_i.wr(4'hA, 1'b1, 3, 4);
    repeat (10) @(posedge clk);
    pairs = 0;
    wb(ADDR_STATUS, 1'b0, 32'h0);
    chk("overflow", q, 32'h1 << STATUS_OVERFLOW_BIT);
    chk("full", sawFull, 1'b1);
    wb(ADDR_STATUS, 1'b1, 32'h0000_0004);
    wb(ADDR_STATUS, 1'b0, 32'h0);
    chk("cleared", q, 32'h0);
    hold <= 1'b0;
    repeat (40) @(posedge clk);
    // eight buffered pairs plus the one held in the output register
    chk("drained", pairs, 9);
    finish_test;
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    errors++;
    finish_test;
  end
endmodule
`default_nettype wire
